// [mda_consts.svh]
`ifndef MDA_CONSTS_SVH
`define MDA_CONSTS_SVH

// channel geometry
`define MDA_NUM_CH 13
`define MDA_ADDR_W 26
`define MDA_CNT_W 16

// single control registers, byte addresses
`define MDA_OFF_ENABLE 12'h000
`define MDA_OFF_CNT_EN 12'h004
`define MDA_OFF_BURST 12'h008
`define MDA_OFF_DIR 12'h00c
`define MDA_OFF_BYTE_STEP 12'h010
`define MDA_OFF_CH2_JUMP 12'h014
`define MDA_OFF_LOG_SEL 12'h018
`define MDA_OFF_STATUS 12'h01c
`define MDA_OFF_IRQ 12'h020
`define MDA_OFF_HIT 12'h024

// per-channel windows, selected by haddr[11:6], word index haddr[5:2]
`define MDA_WIN_CTRL 6'h00
`define MDA_WIN_ADDR 6'h01
`define MDA_WIN_BLK 6'h02
`define MDA_WIN_BUF 6'h03
`define MDA_WIN_THR 6'h04

// reset values
`define MDA_RST_CNT_EN 13'h1fff

// channel feature masks, bit n is channel n
`define MDA_LIMIT_MASK 13'h1e35
`define MDA_THROTTLE_MASK 13'h1440
`define MDA_BURST_MASK 13'h1ff3

// address steps
`define MDA_STEP_HALF 26'h0000002
`define MDA_STEP_BYTE 26'h0000001

// access size encodings
`define MDA_SIZE_BYTE 2'h0
`define MDA_SIZE_HALF 2'h1

// fixed block limit of the read-only halfword channel
`define MDA_LIMIT_CH 4
`define MDA_LIMIT_KB 16
`define MDA_HALFWORD_BYTES 2
`define MDA_LIMIT_ACCESSES (`MDA_LIMIT_KB * 1024 / `MDA_HALFWORD_BYTES)

`endif

// [mda_pkg.sv]
package mda_pkg;

    // arbiter sequencing
    typedef enum logic [1:0] {
        MDA_IDLE = 2'b00,
        MDA_XFER = 2'b01,
        MDA_DONE = 2'b10
    } mda_state_t;

    // register address regions
    typedef enum logic [2:0] {
        MDA_R_CTRL = 3'b000,
        MDA_R_ADDR = 3'b001,
        MDA_R_BLK = 3'b010,
        MDA_R_BUF = 3'b011,
        MDA_R_THR = 3'b100,
        MDA_R_NONE = 3'b111
    } mda_region_t;

endpackage : mda_pkg

// [mda_sync.sv]
`timescale 1ns/1ns
`default_nettype none

// two-stage synchroniser for levels arriving from pins
module mda_sync #(
    parameter int WIDTH = 4
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);

    logic [WIDTH-1:0] meta;

    // first stage feeds only the second stage
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta <= '0;
            syncOut <= '0;
        end else begin
            meta <= asyncIn;
            syncOut <= meta;
        end
    end

endmodule : mda_sync

`default_nettype wire

// [mda_arbiter.sv]
// Summary of operation
// - channels 0 and 4..12 step address by two
// - channels 1 and 2 may step by one
// - count enable selects stepping or holding address
// - channels 2 and 3 step up or down
// - channel 2 step from its control register
// - channel 3 step from rotation logic inputs
// - fixed priority 0,1,2,3,11,12,4..10
// - burst keeps granting while hold request stays
// - burst ignores higher priority requests
// - throttled channel one access per period
// - only one logical sub-channel active
// - external requests pass two-flop synchronisers
// - channel 4 block limit 16 kB, interrupt
// - internal channels always use halfword size
// - external write channel drives driver disable
// - acknowledge at least two clocks after request
// - double buffer reloads on limit, interrupts
// - block size buffer write clears interrupt
//
// Chosen here: the register addresses and register access over AHB-Lite.
`include "mda_consts.svh"
`timescale 1ns/1ns
`default_nettype none

module mda_arbiter
    import mda_pkg::*;
#(
    parameter int NUM_LOGICAL = 4
) (
    input wire logic core_clk,
    input wire logic rst_n,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // requesters
    input wire logic [1:0] extReq,
    input wire logic [NUM_LOGICAL-1:0] logReq,
    input wire logic [9:0] intReq,
    input wire logic [12:0] burstHoldRequest,
    input wire logic rotStepDown,
    input wire logic [7:0] rotStepAmount,
    output logic [12:0] dmaAck,
    output logic [12:0] dmaBlockInterrupt,
    // system bus master side
    output logic busReq,
    output logic [25:0] busAddr,
    output logic busWrite,
    output logic [3:0] busChannel,
    output logic [1:0] accessSizeSelect,
    output logic busDriverDisable,
    input wire logic busDone
);

    localparam logic [3:0] PRIO_ORDER [13] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'hb, 4'hc,
        4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'ha};
    localparam logic [15:0] LIMIT_MAX = 16'(`MDA_LIMIT_ACCESSES);
    localparam logic [12:0] LIMIT_MASK = `MDA_LIMIT_MASK;
    localparam logic [12:0] THR_MASK = `MDA_THROTTLE_MASK;
    localparam logic [12:0] BURST_MASK = `MDA_BURST_MASK;

    // highest ranked eligible channel, bit 4 marks a hit
    function automatic logic [4:0] mdaPick(input logic [12:0] elig);
        logic [4:0] best;
        best = 5'h00;
        for (int r = 12; r >= 0; r--) begin
            if (elig[PRIO_ORDER[r]]) begin
                best = {1'b1, PRIO_ORDER[r]};
            end
        end
        return best;
    endfunction : mdaPick

    // region of a register address, shared by read and write paths
    function automatic mda_region_t mdaRegion(input logic [31:0] a);
        mda_region_t reg_kind;
        reg_kind = MDA_R_NONE;
        if (a[31:12] == 20'h00000 && a[1:0] == 2'h0) begin
            case (a[11:6])
                `MDA_WIN_CTRL: reg_kind = MDA_R_CTRL;
                `MDA_WIN_ADDR: reg_kind = (a[5:2] < 4'hd) ? MDA_R_ADDR : MDA_R_NONE;
                `MDA_WIN_BLK: reg_kind = (a[5:2] < 4'hd) ? MDA_R_BLK : MDA_R_NONE;
                `MDA_WIN_BUF: reg_kind = (a[5:2] < 4'h4) ? MDA_R_BUF : MDA_R_NONE;
                `MDA_WIN_THR: reg_kind = (a[5:2] < 4'hd) ? MDA_R_THR : MDA_R_NONE;
                default: reg_kind = MDA_R_NONE;
            endcase
        end
        return reg_kind;
    endfunction : mdaRegion

    // software state
    logic [12:0] chanEnable;
    logic [12:0] cntEnable;
    logic [12:0] burstEnable;
    logic [12:0] dirWrite;
    logic [1:0] byteStep;
    logic ch2JumpEn;
    logic ch2Down;
    logic [7:0] ch2Amount;
    logic [1:0] logicalSel;
    logic [25:0] chAddr [13];
    logic [15:0] blkSize [13];
    logic [15:0] blkCount [13];
    logic [15:0] thrValue [13];
    logic [25:0] addrBuf [2];
    logic [15:0] blkBuf [2];
    logic [1:0] bufLoaded;
    logic [12:0] blkHit;

    // engine state
    mda_state_t state;
    mda_state_t next_state;
    logic [3:0] grantCh;
    logic [15:0] thrCount [13];
    logic [12:0] thrBusy;

    // bus slave state
    logic wrPend;
    logic rdPend;
    logic [31:0] wrAddr;
    logic [31:0] rdAddr;

    // pin requests and their burst holds are synchronised
    logic [3:0] pinSync;
    mda_sync #(
        .WIDTH(4)
    ) u_pin_sync (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .asyncIn({burstHoldRequest[2:1], extReq}),
        .syncOut(pinSync)
    );

    // request and burst vectors; channel 0 only hears its selected logical source
    wire [3:0] logOneHot = 4'h1 << logicalSel;
    wire logSelReq = |(logReq & logOneHot[NUM_LOGICAL-1:0]);
    wire [12:0] chReq = {intReq, pinSync[1:0], logSelReq};
    wire [12:0] chBurst = {burstHoldRequest[12:3], pinSync[3:2], burstHoldRequest[0]};

    // per-channel step, limit and throttle logic
    logic [25:0] nextAddr [13];
    logic [15:0] blkLimit [13];
    genvar g;
    generate
        for (g = 0; g < 13; g++) begin : g_ch
            wire stepDown;
            wire [25:0] stepAmt;
            if (g == 3) begin : g_rot
                assign stepDown = rotStepDown;
                assign stepAmt = {18'h00000, rotStepAmount};
            end else if (g == 2) begin : g_jump
                assign stepDown = ch2JumpEn & ch2Down;
                assign stepAmt = ch2JumpEn ? {18'h00000, ch2Amount} :
                    (byteStep[1] ? `MDA_STEP_BYTE : `MDA_STEP_HALF);
            end else if (g == 1) begin : g_byte
                assign stepDown = 1'b0;
                assign stepAmt = byteStep[0] ? `MDA_STEP_BYTE : `MDA_STEP_HALF;
            end else begin : g_half
                assign stepDown = 1'b0;
                assign stepAmt = `MDA_STEP_HALF;
            end
            // held address when counting is switched off
            assign nextAddr[g] = !cntEnable[g] ? chAddr[g] :
                (stepDown ? chAddr[g] - stepAmt : chAddr[g] + stepAmt);
            if (g == `MDA_LIMIT_CH) begin : g_fixed
                // zero or oversize programming falls back to the hard ceiling
                assign blkLimit[g] = (blkSize[g] == 16'h0000 || blkSize[g] > LIMIT_MAX) ?
                    LIMIT_MAX : blkSize[g];
            end else begin : g_prog
                assign blkLimit[g] = LIMIT_MASK[g] ? blkSize[g] : 16'h0000;
            end
            if (THR_MASK[g]) begin : g_thr
                // reload on each completed access, count down to zero
                always_ff @(posedge core_clk or negedge rst_n) begin
                    if (!rst_n) begin
                        thrCount[g] <= 16'h0000;
                    end else if (state == MDA_XFER && busDone && grantCh == 4'(g)) begin
                        thrCount[g] <= thrValue[g];
                    end else if (thrCount[g] != 16'h0000) begin
                        thrCount[g] <= thrCount[g] - 16'h0001;
                    end
                end
            end else begin : g_nothr
                assign thrCount[g] = 16'h0000;
            end
            assign thrBusy[g] = thrCount[g] != 16'h0000;
        end
    endgenerate

    // eligibility and selection
    wire [12:0] eligible = chanEnable & chReq & ~blkHit & ~thrBusy;
    wire [4:0] pick = mdaPick(eligible);
    wire completeNow = (state == MDA_XFER) && busDone;
    wire [15:0] countInc = blkCount[grantCh] + 16'h0001;
    wire limitReached = blkLimit[grantCh] != 16'h0000 && countInc == blkLimit[grantCh];
    wire isDbuf = grantCh == 4'h0 || grantCh == 4'h2;
    wire bufIdx = grantCh[1];
    // a burst stays only with its own channel, others wait
    wire burstGo = BURST_MASK[grantCh] && burstEnable[grantCh] && chBurst[grantCh]
        && !(limitReached && !(isDbuf && bufLoaded[bufIdx])) && thrValue[grantCh] == 16'h0000;
    wire isExtCh = grantCh == 4'h1 || grantCh == 4'h2;
    wire [12:0] grantHot = 13'h0001 << grantCh;
    wire [12:0] irqSet = (completeNow && limitReached) ? grantHot : 13'h0000;

    // bus address decode, writes commit in their data phase
    wire addrPhase = hsel && htrans[1] && hready && hsize == 3'h2;
    mda_region_t wrRegion;
    mda_region_t rdRegion;
    assign wrRegion = mdaRegion(wrAddr);
    assign rdRegion = mdaRegion(rdAddr);
    wire [3:0] wrIdx = wrAddr[5:2];
    wire [3:0] rdIdx = rdAddr[5:2];
    wire wrCtrl = wrPend && wrRegion == MDA_R_CTRL;
    wire wrBlk = wrPend && wrRegion == MDA_R_BLK;
    wire wrBuf = wrPend && wrRegion == MDA_R_BUF;
    wire [12:0] irqClr = wrBlk ? 13'h0001 << wrIdx :
        (wrBuf && wrIdx[0]) ? 13'h0001 << {wrIdx[1], 1'b0} : 13'h0000;

    // read mux
    logic [31:0] readValue;
    always_comb begin
        readValue = 32'h00000000;
        case (rdRegion)
            MDA_R_ADDR: readValue = {6'h00, chAddr[rdIdx]};
            MDA_R_BLK: readValue = {blkCount[rdIdx], blkSize[rdIdx]};
            MDA_R_BUF: readValue = rdIdx[0] ? {16'h0000, blkBuf[rdIdx[1]]} : {6'h00, addrBuf[rdIdx[1]]};
            MDA_R_THR: readValue = {thrCount[rdIdx], thrValue[rdIdx]};
            MDA_R_CTRL: begin
                case (rdAddr[11:0])
                    `MDA_OFF_ENABLE: readValue = {19'h00000, chanEnable};
                    `MDA_OFF_CNT_EN: readValue = {19'h00000, cntEnable};
                    `MDA_OFF_BURST: readValue = {19'h00000, burstEnable};
                    `MDA_OFF_DIR: readValue = {19'h00000, dirWrite};
                    `MDA_OFF_BYTE_STEP: readValue = {30'h00000000, byteStep};
                    `MDA_OFF_CH2_JUMP: readValue = {22'h000000, ch2JumpEn, ch2Down, ch2Amount};
                    `MDA_OFF_LOG_SEL: readValue = {30'h00000000, logicalSel};
                    `MDA_OFF_STATUS: readValue = {12'h000, eligible, bufLoaded, grantCh, state != MDA_IDLE};
                    `MDA_OFF_IRQ: readValue = {19'h00000, dmaBlockInterrupt};
                    `MDA_OFF_HIT: readValue = {19'h00000, blkHit};
                    default: readValue = 32'h00000000;
                endcase
            end
            default: readValue = 32'h00000000;
        endcase
    end

    // slave handshake: writes zero wait, reads one wait so data is registered
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wrPend <= 1'b0;
            rdPend <= 1'b0;
            wrAddr <= 32'h00000000;
            rdAddr <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            hrdata <= 32'h00000000;
        end else begin
            wrPend <= addrPhase && hwrite;
            rdPend <= addrPhase && !hwrite;
            hreadyout <= !(addrPhase && !hwrite);
            if (addrPhase) begin
                wrAddr <= haddr;
                rdAddr <= haddr;
            end
            if (rdPend) begin
                hrdata <= readValue;
            end
        end
    end

    // control registers written by software only
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            chanEnable <= 13'h0000;
            cntEnable <= `MDA_RST_CNT_EN;
            burstEnable <= 13'h0000;
            dirWrite <= 13'h0000;
            byteStep <= 2'h0;
            ch2JumpEn <= 1'b0;
            ch2Down <= 1'b0;
            ch2Amount <= 8'h00;
            logicalSel <= 2'h0;
        end else if (wrCtrl) begin
            case (wrAddr[11:0])
                `MDA_OFF_ENABLE: chanEnable <= hwdata[12:0];
                `MDA_OFF_CNT_EN: cntEnable <= hwdata[12:0];
                `MDA_OFF_BURST: burstEnable <= hwdata[12:0];
                `MDA_OFF_DIR: dirWrite <= hwdata[12:0];
                `MDA_OFF_BYTE_STEP: byteStep <= hwdata[1:0];
                `MDA_OFF_CH2_JUMP: begin
                    ch2Amount <= hwdata[7:0];
                    ch2Down <= hwdata[8];
                    ch2JumpEn <= hwdata[9];
                end
                // switching logical source only while channel 0 is idle is up to software
                `MDA_OFF_LOG_SEL: logicalSel <= hwdata[1:0];
                default: ;
            endcase
        end
    end

    // channel counters: engine updates first, a software write in the same cycle wins
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 13; i++) begin
                chAddr[i] <= 26'h0000000;
                blkSize[i] <= 16'h0000;
                blkCount[i] <= 16'h0000;
                thrValue[i] <= 16'h0000;
            end
            for (int j = 0; j < 2; j++) begin
                addrBuf[j] <= 26'h0000000;
                blkBuf[j] <= 16'h0000;
            end
            bufLoaded <= 2'h0;
            blkHit <= 13'h0000;
        end else begin
            // hit clear goes first so a limit reached in the same cycle survives
            if (wrBlk) begin
                blkHit[wrIdx] <= 1'b0;
            end
            if (completeNow) begin
                chAddr[grantCh] <= nextAddr[grantCh];
                blkCount[grantCh] <= countInc;
                if (limitReached && isDbuf && bufLoaded[bufIdx]) begin
                    chAddr[grantCh] <= addrBuf[bufIdx];
                    blkSize[grantCh] <= blkBuf[bufIdx];
                    blkCount[grantCh] <= 16'h0000;
                    bufLoaded[bufIdx] <= 1'b0;
                end else if (limitReached) begin
                    blkHit[grantCh] <= 1'b1;
                end
            end
            if (wrPend && wrRegion == MDA_R_ADDR) begin
                chAddr[wrIdx] <= hwdata[25:0];
            end
            if (wrBlk) begin
                blkSize[wrIdx] <= hwdata[15:0];
                blkCount[wrIdx] <= 16'h0000;
            end
            if (wrBuf) begin
                if (wrIdx[0]) begin
                    blkBuf[wrIdx[1]] <= hwdata[15:0];
                end else begin
                    addrBuf[wrIdx[1]] <= hwdata[25:0];
                end
                bufLoaded[wrIdx[1]] <= 1'b1;
            end
            if (wrPend && wrRegion == MDA_R_THR) begin
                thrValue[wrIdx] <= hwdata[15:0];
            end
        end
    end

    // sticky block interrupts, a set in the clearing cycle survives
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            dmaBlockInterrupt <= 13'h0000;
        end else begin
            dmaBlockInterrupt <= (dmaBlockInterrupt & ~irqClr) | irqSet;
        end
    end

    // sequencer: grant, transfer, settle, then arbitrate again
    always_comb begin
        next_state = state;
        case (state)
            MDA_IDLE: next_state = pick[4] ? MDA_XFER : MDA_IDLE;
            MDA_XFER: next_state = (busDone && !burstGo) ? MDA_DONE : MDA_XFER;
            MDA_DONE: next_state = MDA_IDLE;
            default: next_state = MDA_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= MDA_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // grant and master-side outputs
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            grantCh <= 4'h0;
            busReq <= 1'b0;
            busAddr <= 26'h0000000;
            busWrite <= 1'b0;
            busChannel <= 4'h0;
            accessSizeSelect <= `MDA_SIZE_HALF;
            busDriverDisable <= 1'b0;
            dmaAck <= 13'h0000;
        end else begin
            dmaAck <= 13'h0000;
            // only an idle engine looks at new requests
            if (state == MDA_IDLE && pick[4]) begin
                grantCh <= pick[3:0];
                busChannel <= pick[3:0];
                busReq <= 1'b1;
                busAddr <= chAddr[pick[3:0]];
                busWrite <= dirWrite[pick[3:0]];
                accessSizeSelect <= ((pick[3:0] == 4'h1 && byteStep[0]) || (pick[3:0] == 4'h2 && byteStep[1]))
                    ? `MDA_SIZE_BYTE : `MDA_SIZE_HALF;
                busDriverDisable <= (pick[3:0] == 4'h1 || pick[3:0] == 4'h2) && dirWrite[pick[3:0]];
            end
            // ack follows completion, so never earlier than two clocks after the request
            if (completeNow) begin
                dmaAck <= grantHot;
                if (burstGo) begin
                    busAddr <= (limitReached && isDbuf && bufLoaded[bufIdx]) ? addrBuf[bufIdx] :
                        nextAddr[grantCh];
                end else begin
                    busReq <= 1'b0;
                    busDriverDisable <= 1'b0;
                end
            end
            if (completeNow && !burstGo && isExtCh) begin
                busDriverDisable <= 1'b0;
            end
        end
    end

endmodule : mda_arbiter

`default_nettype wire

// [mda_bus_model.sv]
`timescale 1ns/1ns
`default_nettype none

module mda_bus_model (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic busReq,
    input wire logic [3:0] latency,
    output logic busDone
);
    logic [3:0] waitCnt;

    // finish each access after latency cycles; done always drops a cycle so one pulse means one access
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            waitCnt <= 4'h0;
            busDone <= 1'b0;
        end else if (busReq && !busDone && waitCnt >= latency) begin
            waitCnt <= 4'h0;
            busDone <= 1'b1;
        end else begin
            waitCnt <= (busReq && !busDone) ? waitCnt + 4'h1 : 4'h0;
            busDone <= 1'b0;
        end
    end
endmodule : mda_bus_model
`default_nettype wire

// [mda_arbiter_properties.sv]
`include "mda_consts.svh"
`timescale 1ns/1ns
`default_nettype none

module mda_arbiter_properties (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [12:0] dmaAck,
    input wire logic busReq,
    input wire logic [25:0] busAddr,
    input wire logic busWrite,
    input wire logic [3:0] busChannel,
    input wire logic [1:0] accessSizeSelect,
    input wire logic busDriverDisable,
    input wire logic busDone
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    // an access ends and the grant carries on into the next one
    sequence sBurstStep;
        busReq && busDone ##1 busReq;
    endsequence

    AST_ACK_ONEHOT: assert property ($onehot0(dmaAck)) else $error("ack not one-hot");
    AST_ACK_AFTER_DONE: assert property (busReq && busDone |=> dmaAck == (13'h1 << $past(busChannel)))
        else $error("ack missing after done");
    AST_NO_EARLY_ACK: assert property ($rose(busReq) |-> dmaAck == 13'h0) else $error("ack with grant");
    AST_HALF_SIZE: assert property (busReq && busChannel >= 4'h3 |-> accessSizeSelect == `MDA_SIZE_HALF)
        else $error("internal channel not halfword");
    AST_DRV_DISABLE: assert property (busDriverDisable == (busReq && busWrite
        && (busChannel == 4'h1 || busChannel == 4'h2))) else $error("driver disable wrong");
    AST_STEP_TWO: assert property (busChannel >= 4'h4 && busReq && busDone ##1 busReq
        |-> busAddr == $past(busAddr) + 26'h2) else $error("burst step not two");
    AST_BURST_SAME: assert property (sBurstStep |-> $stable(busChannel)) else $error("burst lost");
    AST_SETTLE: assert property ($fell(busReq) |-> !busReq ##1 !busReq) else $error("regrant too soon");
endmodule : mda_arbiter_properties

bind mda_arbiter mda_arbiter_properties uProps (
    .core_clk(core_clk), .rst_n(rst_n), .dmaAck(dmaAck), .busReq(busReq), .busAddr(busAddr),
    .busWrite(busWrite), .busChannel(busChannel), .accessSizeSelect(accessSizeSelect),
    .busDriverDisable(busDriverDisable), .busDone(busDone)
);
`default_nettype wire

// [mda_arbiter_bench.sv]
`timescale 1ns/1ns
`default_nettype none

module mda_arbiter_bench;
    logic core_clk, rst_n, hsel, hwrite, busDone, rotStepDown, hreadyout, hresp;
    logic busReq, busWrite, busDriverDisable;
    logic [31:0] haddr, hwdata, hrdata, q;
    logic [1:0] htrans, extReq, accessSizeSelect;
    logic [2:0] hsize = 3'h2;
    logic [3:0] logReq, lat, busChannel;
    logic [9:0] intReq;
    logic [12:0] burstHoldRequest, dmaAck, dmaBlockInterrupt;
    logic [7:0] rotStepAmount;
    logic [25:0] busAddr;
    int err_count = 0;
    int checked = 0;
    time t0;

    mda_arbiter DUT (.core_clk(core_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .extReq(extReq), .logReq(logReq), .intReq(intReq),
        .burstHoldRequest(burstHoldRequest), .rotStepDown(rotStepDown), .rotStepAmount(rotStepAmount),
        .dmaAck(dmaAck), .dmaBlockInterrupt(dmaBlockInterrupt), .busReq(busReq), .busAddr(busAddr),
        .busWrite(busWrite), .busChannel(busChannel), .accessSizeSelect(accessSizeSelect),
        .busDriverDisable(busDriverDisable), .busDone(busDone));
    mda_bus_model uBus (.core_clk(core_clk), .rst_n(rst_n), .busReq(busReq), .latency(lat), .busDone(busDone));

    // 100 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    task automatic wrap_up();
        $display("checked %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : wrap_up

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    // one ahb-lite single word transfer; address held until hready, then data phase
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask : xfer

    task automatic rd(input logic [31:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        chk(q, e);
        chk(hresp, 32'h0);
    endtask : rd

    // wait for the grant, check channel and address, then wait for its ack
    task automatic serve(input logic [3:0] ch, input logic [25:0] a);
        int n;
        n = 0;
        while (busReq !== 1'b1 && n < 300) begin
            @(posedge core_clk);
            n++;
        end
        chk(busChannel, ch);
        chk(busAddr, a);
        do begin
            @(posedge core_clk);
            n++;
        end while (dmaAck[ch] !== 1'b1 && n < 600);
        chk(dmaAck[ch], 32'h1);
    endtask : serve

    // watchdog, far beyond the few hundred cycles the run needs
    initial begin
        #200000;
        err_count++;
        wrap_up();
    end

    initial begin
        {hsel, hwrite, htrans, haddr, hwdata, extReq, logReq, intReq, burstHoldRequest} = '0;
        rotStepDown = 1'b1;
        rotStepAmount = 8'h10;
        lat = 4'h1;
        rst_n = 1'b0;
        repeat (5) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        rd(32'h004, 32'h1fff);
        rd(32'h3f0, 32'h0);
        xfer(1'b1, 32'h000, 32'h1fff);
        xfer(1'b1, 32'h050, 32'h200);
        xfer(1'b1, 32'h06c, 32'h300);
        xfer(1'b1, 32'h070, 32'h400);
        intReq <= 10'h302;
        serve(4'd11, 26'h300);
        intReq[8] <= 1'b0;
        serve(4'd12, 26'h400);
        intReq[9] <= 1'b0;
        serve(4'd4, 26'h200);
        intReq[1] <= 1'b0;
        xfer(1'b1, 32'h004, 32'h1fef);
        intReq[1] <= 1'b1;
        serve(4'd4, 26'h202);
        serve(4'd4, 26'h202);
        intReq[1] <= 1'b0;
        // burst on channel 5 with slow bus; channel 3 asks meanwhile and must wait
        xfer(1'b1, 32'h008, 32'h20);
        xfer(1'b1, 32'h054, 32'h500);
        xfer(1'b1, 32'h04c, 32'h600);
        lat <= 4'h4;
        burstHoldRequest[5] <= 1'b1;
        intReq[2] <= 1'b1;
        serve(4'd5, 26'h500);
        intReq[0] <= 1'b1;
        serve(4'd5, 26'h502);
        burstHoldRequest[5] <= 1'b0;
        serve(4'd5, 26'h504);
        intReq[2] <= 1'b0;
        serve(4'd3, 26'h600);
        serve(4'd3, 26'h5f0);
        rotStepDown <= 1'b0;
        serve(4'd3, 26'h5e0);
        serve(4'd3, 26'h5f0);
        intReq[0] <= 1'b0;
        // channel 2: jump down 4, block of 2, one buffered reload
        lat <= 4'h0;
        xfer(1'b1, 32'h048, 32'h800);
        xfer(1'b1, 32'h014, 32'h304);
        xfer(1'b1, 32'h088, 32'h2);
        xfer(1'b1, 32'h0c8, 32'h900);
        xfer(1'b1, 32'h0cc, 32'h2);
        extReq[1] <= 1'b1;
        serve(4'd2, 26'h800);
        serve(4'd2, 26'h7fc);
        serve(4'd2, 26'h900);
        serve(4'd2, 26'h8fc);
        extReq[1] <= 1'b0;
        rd(32'h020, 32'h4);
        chk(dmaBlockInterrupt, 13'h4);
        xfer(1'b1, 32'h0cc, 32'h2);
        rd(32'h020, 32'h0);
        // channel 1 writes bytes; request dropped early since the synchroniser lags
        xfer(1'b1, 32'h00c, 32'h2);
        xfer(1'b1, 32'h010, 32'h1);
        xfer(1'b1, 32'h044, 32'h700);
        extReq[0] <= 1'b1;
        serve(4'd1, 26'h700);
        extReq[0] <= 1'b0;
        serve(4'd1, 26'h701);
        chk(accessSizeSelect, 32'h0);
        // throttled channel 6, 30 cycles apart at least
        xfer(1'b1, 32'h118, 32'h1e);
        intReq[3] <= 1'b1;
        serve(4'd6, 26'h0);
        t0 = $time;
        serve(4'd6, 26'h2);
        chk($time - t0 >= 300, 32'h1);
        intReq[3] <= 1'b0;
        // logical sub-channel select on channel 0
        logReq <= 4'h2;
        xfer(1'b1, 32'h018, 32'h2);
        chk(busReq, 32'h0);
        logReq <= 4'h4;
        serve(4'd0, 26'h0);
        logReq <= 4'h0;
        wrap_up();
    end
endmodule : mda_arbiter_bench
`default_nettype wire
